// ===== hdl/serial_ctrl_pkg.sv
// Shared types and constants of the serial control slave
package serial_ctrl_pkg;
  // Link states, Gray steps along init, idle, command, gap, response, done, tail
  typedef enum logic [2:0] {
    ST_INIT = 3'h4,
    ST_IDLE = 3'h0,
    ST_CMD = 3'h1,
    ST_GAP = 3'h3,
    ST_RESP = 3'h2,
    ST_DONE = 3'h6,
    ST_TAIL = 3'h7,
    ST_ACK = 3'h5
  } link_state_type;
  // Slave addresses
  localparam logic [2:0] ADDR_INDIVIDUAL = 3'h2;
  localparam logic [2:0] ADDR_BROADCAST = 3'h7;
  // Command byte fields
  localparam int ADDR_LSB = 0;
  localparam int ADDR_MSB = 2;
  localparam int RW_BIT = 3;
  localparam int IDX_LSB = 4;
  localparam int IDX_MSB = 7;
  // Index commands
  localparam logic [3:0] IDX_CTRL0 = 4'h0;
  localparam logic [3:0] IDX_CTRL1 = 4'h1;
  localparam logic [3:0] IDX_CTRL2 = 4'h2;
  localparam logic [3:0] IDX_RESET = 4'hd;
  localparam logic [3:0] IDX_EXT = 4'hf;
  localparam logic [7:0] EXT_ID_INDEX = 8'h00;
  // Bit positions inside a framed byte, start bit at zero
  localparam logic [3:0] BIT_START = 4'h0;
  localparam logic [3:0] BIT_FIRST = 4'h1;
  localparam logic [3:0] BIT_LAST = 4'h8;
  // Serial clock counts
  localparam int INIT_CYCLES = 30;
  localparam logic [4:0] INIT_LAST = 5'(INIT_CYCLES - 1);
  localparam logic [2:0] GAP_FIRST = 3'h1;
  localparam logic [2:0] RESP_DELAY = 3'h4;
  // Register layout and reset values
  localparam int CTRL0_W = 5;
  localparam int MODE_W = 8;
  localparam int POWER_W = 4;
  localparam int POWER_LSB = 4;
  localparam int ACTIVE_BIT = 0;
  localparam int RXOE_BIT = 1;
  localparam int TXEN_BIT = 2;
  localparam int ACKNOWLEDGE_ENABLE_BIT_BIT = 3;
  localparam logic [4:0] CTRL0_RESET = 5'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [3:0] POWER_RESET = 4'h7;
  // Read line levels
  localparam logic START_RD = 1'h0;
  localparam logic IDLE_RD = 1'h1;
  localparam logic ACK_RD = 1'h0;
endpackage : serial_ctrl_pkg

// ===== hdl/config_if.sv
// Configuration carrier from the link domain to the core domain
`timescale 1ns/1ps
interface config_if;
  import serial_ctrl_pkg::*;
  logic [CTRL0_W-1:0] ctrl0; // Common control
  logic [MODE_W-1:0] mode; // Infrared mode
  logic [POWER_W-1:0] power; // Transmit power level
  logic cfg_toggle; // Flips on every register change
  logic rst_toggle; // Flips on a reset command
  modport link (output ctrl0, output mode, output power, output cfg_toggle, output rst_toggle);
  modport core (input ctrl0, input mode, input power, input cfg_toggle, input rst_toggle);
endinterface : config_if

// ===== hdl/reset_release.sv
// Reset synchroniser: asynchronous assert, two-flop release
`timescale 1ns/1ps
module reset_release (
  input wire logic clk,
  input wire logic rst_n,
  output logic rst_sync_n
);
  logic stage_reg; // First release stage

  // Release reaches the domain only on its own clock edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_reg <= 1'h0;
      rst_sync_n <= 1'h0;
    end else begin
      stage_reg <= 1'h1;
      rst_sync_n <= stage_reg;
    end
  end
endmodule : reset_release

// ===== hdl/config_cross.sv
// Core-domain capture of the link configuration
`timescale 1ns/1ps
module config_cross
  import serial_ctrl_pkg::*;
(
  input wire logic mclk,
  input wire logic mrst_n,
  config_if.core cfg,
  output logic core_active,
  output logic [MODE_W-1:0] core_ir_mode,
  output logic [POWER_W-1:0] core_tx_power,
  output logic core_reset_pulse
);
  logic [1:0] tog_in; // Toggles from the link domain
  logic [1:0] s1_reg; // First stages, read only by s2
  logic [1:0] s2_reg;
  logic [1:0] s3_reg;
  logic [1:0] stable_reg; // Value once stages two and three agree
  logic [1:0] seen_reg; // Previous stable value
  logic [1:0] evt; // One-cycle events

  assign tog_in = {cfg.rst_toggle, cfg.cfg_toggle};

  // Three-flop crossing per toggle, change counts when stages agree
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge mclk or negedge mrst_n) begin
      if (!mrst_n) begin
        s1_reg[i] <= 1'h0;
        s2_reg[i] <= 1'h0;
        s3_reg[i] <= 1'h0;
        stable_reg[i] <= 1'h0;
        seen_reg[i] <= 1'h0;
      end else begin
        s1_reg[i] <= tog_in[i];
        s2_reg[i] <= s1_reg[i];
        s3_reg[i] <= s2_reg[i];
        if (s2_reg[i] == s3_reg[i]) begin
          stable_reg[i] <= s3_reg[i];
        end
        seen_reg[i] <= stable_reg[i];
      end
    end
    assign evt[i] = stable_reg[i] ^ seen_reg[i];
  end

  // Words are held in the link domain long before the toggle lands
  always_ff @(posedge mclk or negedge mrst_n) begin
    if (!mrst_n) begin
      core_active <= CTRL0_RESET[ACTIVE_BIT];
      core_ir_mode <= MODE_RESET;
      core_tx_power <= POWER_RESET;
      core_reset_pulse <= 1'h0;
    end else begin
      if (evt[0]) begin
        core_active <= cfg.ctrl0[ACTIVE_BIT];
        core_ir_mode <= cfg.mode;
        core_tx_power <= cfg.power;
      end
      core_reset_pulse <= evt[1];
    end
  end
endmodule : config_cross

// ===== hdl/transceiver_serial_control_slave.sv
// Serial control slave of an infrared transceiver, link and core sides
// What this block does
// - Only answer transactions the master starts
// - Command phase always; response only for reads
// - Response starts four clocks after last bit
// - Bytes follow back to back, no gaps
// - Bytes travel least significant bit first
// - Receivers sample data on rising clock edge
// - Slave updates read line on rising edge
// - One start bit precedes every byte
// - Idle write line passes through to LED
// - First rising clock edge disables LED drive
// - LED back on at last command cycle of a write
// - Photodiode blocked from read line in response
// - Addressed slave drives despite receiver disable
// - Unaddressed slave keeps read line released
// - Idle: transmit line low, receive high
// - Acknowledge enabled: one low pulse after writes
// - Read end found by watching write line
// - Decode address 010, broadcast 111
// - Power-on: sleep, released, LED off, slowest mode
`timescale 1ns/1ps
module transceiver_serial_control_slave
  import serial_ctrl_pkg::*;
#(
  parameter logic [7:0] EXT_ID_CODE = 8'h5a // Arbitrary identity value
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic write_data_line,
  input wire logic photodiode_rx,
  output logic read_data_line_o,
  output logic read_data_line_oe,
  output logic led_drive,
  output logic core_active,
  output logic [MODE_W-1:0] core_ir_mode,
  output logic [POWER_W-1:0] core_tx_power,
  output logic core_reset_pulse
);
  logic mrst_n; // Core-domain reset copy
  logic srst_n; // Link-domain reset copy

  // The link clock stops between frames, so it gets its own release
  reset_release u_mrst (
    .clk(mclk),
    .rst_n(rst_n),
    .rst_sync_n(mrst_n)
  );
  reset_release u_srst (
    .clk(sclk),
    .rst_n(rst_n),
    .rst_sync_n(srst_n)
  );

  link_state_type state_reg; // Link sequencer
  logic [3:0] bit_cnt_reg; // Position within a framed byte
  logic byte_cnt_reg; // Second command byte pending
  logic [2:0] gap_cnt_reg; // Clocks since last command bit
  logic [4:0] init_cnt_reg; // Low-line clocks seen in init
  logic [7:0] rx_sh_reg; // Incoming byte, LSB first
  logic [7:0] tx_sh_reg; // Outgoing byte
  logic rd_reg; // Transaction is a read
  logic [3:0] idx_reg; // Index command
  logic sel_wr_reg; // Addressed for writes
  logic sel_rd_reg; // Addressed for reads
  logic [7:0] ext_idx_reg; // Extended index
  logic led_en_reg; // LED pass-through gate
  logic rdl_out_reg; // Read line level in a transaction
  logic rdl_oe_reg; // Read line drive in a transaction
  logic [CTRL0_W-1:0] ctrl0_reg; // Common control
  logic [MODE_W-1:0] mode_reg; // Infrared mode
  logic [POWER_W-1:0] power_reg; // Transmit power
  logic cfg_tog_reg; // Register change event
  logic rst_tog_reg; // Reset command event

  logic [7:0] rx_byte; // Byte as completed this edge
  logic byte_done; // Last data bit of a byte
  logic first_byte; // Byte is the address byte
  logic [2:0] f_addr;
  logic f_rd;
  logic [3:0] f_idx;
  logic f_sel_wr;
  logic f_sel_rd;
  logic end_wr; // Write or special command complete
  logic end_rd; // Read command phase complete
  logic reg_rst; // Addressed reset command
  logic reg_we; // Addressed register write
  logic ack_go; // Acknowledge pulse due
  logic resp_go; // Response start bit due
  logic line_low; // Write line sampled low
  logic pass_mode; // No transaction in progress
  logic [7:0] resp_byte; // Value to return

  assign rx_byte = {write_data_line, rx_sh_reg[7:1]};
  assign byte_done = (state_reg == ST_CMD) && (bit_cnt_reg == BIT_LAST);
  assign first_byte = !byte_cnt_reg;
  assign f_addr = rx_byte[ADDR_MSB:ADDR_LSB];
  assign f_rd = rx_byte[RW_BIT];
  assign f_idx = rx_byte[IDX_MSB:IDX_LSB];
  assign f_sel_wr = (f_addr == ADDR_INDIVIDUAL) || (f_addr == ADDR_BROADCAST);
  assign f_sel_rd = (f_addr == ADDR_INDIVIDUAL);
  assign end_wr = byte_done && (first_byte ? (!f_rd && (f_idx == IDX_RESET)) : !rd_reg);
  assign end_rd = byte_done && (first_byte ? (f_rd && (f_idx != IDX_EXT)) : rd_reg);
  assign reg_rst = end_wr && first_byte && f_sel_wr;
  assign reg_we = end_wr && !first_byte && sel_wr_reg;
  assign ack_go = end_wr && ctrl0_reg[ACKNOWLEDGE_ENABLE_BIT_BIT] && (first_byte ? f_sel_wr : sel_wr_reg);
  // fourth clock after the last bit
  assign resp_go = (state_reg == ST_GAP) && (gap_cnt_reg == RESP_DELAY) && write_data_line;
  assign line_low = !write_data_line;
  assign pass_mode = (state_reg == ST_IDLE) || (state_reg == ST_INIT);

  // Read value; unused bits and unused indices read zero
  always_comb begin
    resp_byte = 8'h00;
    if (idx_reg == IDX_EXT) begin
      if (ext_idx_reg == EXT_ID_INDEX) begin
        resp_byte = EXT_ID_CODE;
      end
    end else begin
      case (idx_reg)
        IDX_CTRL0: resp_byte = {3'h0, ctrl0_reg};
        IDX_CTRL1: resp_byte = mode_reg;
        IDX_CTRL2: resp_byte = {power_reg, 4'h0};
        default: resp_byte = 8'h00;
      endcase
    end
  end

  // Sequencer; every move waits for a master edge
  always_ff @(posedge sclk or negedge srst_n) begin
    if (!srst_n) begin
      state_reg <= ST_INIT;
    end else begin
      case (state_reg)
        // init restarts on a high line
        ST_INIT: begin
          if (!write_data_line && (init_cnt_reg == INIT_LAST)) begin
            state_reg <= ST_IDLE;
          end
        end
        // any edge starts a master transaction
        ST_IDLE: state_reg <= ST_CMD;
        ST_CMD: begin
          if (end_rd) begin
            state_reg <= ST_GAP;
          end else if (ack_go) begin
            state_reg <= ST_ACK;
          end else if (end_wr) begin
            state_reg <= ST_IDLE;
          end
        end
        // a low line here means the master gave up
        ST_GAP: begin
          if (line_low) begin
            state_reg <= ST_TAIL;
          end else if (gap_cnt_reg == RESP_DELAY) begin
            state_reg <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (line_low) begin
            state_reg <= ST_TAIL;
          end else if (bit_cnt_reg == BIT_LAST) begin
            state_reg <= ST_DONE;
          end
        end
        // end of read seen on the write line
        ST_DONE: begin
          if (line_low) begin
            state_reg <= ST_TAIL;
          end
        end
        ST_TAIL: state_reg <= ST_IDLE;
        ST_ACK: state_reg <= ST_IDLE;
        default: state_reg <= ST_INIT;
      endcase
    end
  end

  always_ff @(posedge sclk or negedge srst_n) begin
    if (!srst_n) begin
      init_cnt_reg <= 5'h00;
    end else if (state_reg == ST_INIT) begin
      if (write_data_line) begin
        init_cnt_reg <= 5'h00;
      end else begin
        init_cnt_reg <= init_cnt_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge sclk or negedge srst_n) begin
    if (!srst_n) begin
      bit_cnt_reg <= BIT_START;
      byte_cnt_reg <= 1'h0;
      gap_cnt_reg <= GAP_FIRST;
    end else begin
      case (state_reg)
        // first edge already took the start bit
        ST_IDLE: begin
          bit_cnt_reg <= BIT_FIRST;
          byte_cnt_reg <= 1'h0;
        end
        ST_CMD: begin
          gap_cnt_reg <= GAP_FIRST;
          // next byte's start bit follows directly
          if (bit_cnt_reg == BIT_START) begin
            bit_cnt_reg <= BIT_FIRST;
          end else if (bit_cnt_reg == BIT_LAST) begin
            bit_cnt_reg <= BIT_START;
            byte_cnt_reg <= 1'h1;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
        ST_GAP: begin
          gap_cnt_reg <= gap_cnt_reg + 3'h1;
          if (resp_go) begin
            bit_cnt_reg <= BIT_FIRST;
          end
        end
        ST_RESP: bit_cnt_reg <= bit_cnt_reg + 4'h1;
        default: bit_cnt_reg <= BIT_START;
      endcase
    end
  end

  // command data taken on rising edges
  always_ff @(posedge sclk or negedge srst_n) begin
    if (!srst_n) begin
      rx_sh_reg <= 8'h00;
      rd_reg <= 1'h0;
      idx_reg <= IDX_CTRL0;
      sel_wr_reg <= 1'h0;
      sel_rd_reg <= 1'h0;
      ext_idx_reg <= EXT_ID_INDEX;
    end else if ((state_reg == ST_CMD) && (bit_cnt_reg != BIT_START)) begin
      rx_sh_reg <= rx_byte;
      if (byte_done && first_byte) begin
        rd_reg <= f_rd;
        idx_reg <= f_idx;
        sel_wr_reg <= f_sel_wr;
        sel_rd_reg <= f_sel_rd;
      end else if (byte_done && rd_reg) begin
        ext_idx_reg <= rx_byte;
      end
    end
  end

  // read line changes on rising edges
  always_ff @(posedge sclk or negedge srst_n) begin
    if (!srst_n) begin
      rdl_out_reg <= IDLE_RD;
      rdl_oe_reg <= 1'h0;
      tx_sh_reg <= 8'h00;
    end else begin
      case (state_reg)
        ST_CMD: begin
          if (ack_go) begin
            rdl_out_reg <= ACK_RD;
            rdl_oe_reg <= 1'h1;
          end
        end
        ST_GAP: begin
          // start bit ahead of the read byte
          if (resp_go) begin
            rdl_out_reg <= START_RD;
            rdl_oe_reg <= sel_rd_reg;
            tx_sh_reg <= resp_byte;
          end
        end
        ST_RESP: begin
          if (line_low) begin
            rdl_out_reg <= IDLE_RD;
            rdl_oe_reg <= 1'h0;
          end else begin
            rdl_out_reg <= tx_sh_reg[0];
            tx_sh_reg <= {1'h0, tx_sh_reg[7:1]};
          end
        end
        ST_DONE: begin
          // Hold the line high until the master ends the read
          rdl_out_reg <= IDLE_RD;
          if (line_low) begin
            rdl_oe_reg <= 1'h0;
          end
        end
        default: begin
          rdl_out_reg <= IDLE_RD;
          rdl_oe_reg <= 1'h0;
        end
      endcase
    end
  end

  // LED gate; relies on the master keeping the clock still when idle
  always_ff @(posedge sclk or negedge srst_n) begin
    if (!srst_n) begin
      led_en_reg <= 1'h0;
    end else begin
      case (state_reg)
        ST_INIT: led_en_reg <= !write_data_line && (init_cnt_reg == INIT_LAST);
        ST_IDLE: led_en_reg <= 1'h0;
        // back on at the last command cycle of a write
        ST_CMD: led_en_reg <= end_wr;
        ST_TAIL: led_en_reg <= 1'h1;
        default: led_en_reg <= led_en_reg;
      endcase
    end
  end

  // power-on defaults and the reset command
  always_ff @(posedge sclk or negedge srst_n) begin
    if (!srst_n) begin
      ctrl0_reg <= CTRL0_RESET;
      mode_reg <= MODE_RESET;
      power_reg <= POWER_RESET;
      cfg_tog_reg <= 1'h0;
      rst_tog_reg <= 1'h0;
    end else begin
      if (reg_rst) begin
        ctrl0_reg <= CTRL0_RESET;
        mode_reg <= MODE_RESET;
        power_reg <= POWER_RESET;
      end else if (reg_we) begin
        case (idx_reg)
          IDX_CTRL0: ctrl0_reg <= rx_byte[CTRL0_W-1:0];
          IDX_CTRL1: mode_reg <= rx_byte;
          IDX_CTRL2: power_reg <= rx_byte[IDX_MSB:POWER_LSB];
          default: ctrl0_reg <= ctrl0_reg;
        endcase
      end
      cfg_tog_reg <= cfg_tog_reg ^ (reg_we | reg_rst);
      rst_tog_reg <= rst_tog_reg ^ reg_rst;
    end
  end

  config_if cfg_bus ();
  assign cfg_bus.ctrl0 = ctrl0_reg;
  assign cfg_bus.mode = mode_reg;
  assign cfg_bus.power = power_reg;
  assign cfg_bus.cfg_toggle = cfg_tog_reg;
  assign cfg_bus.rst_toggle = rst_tog_reg;

  // Core-side copies of the configuration
  config_cross u_cross (
    .mclk(mclk),
    .mrst_n(mrst_n),
    .cfg(cfg_bus.core),
    .core_active(core_active),
    .core_ir_mode(core_ir_mode),
    .core_tx_power(core_tx_power),
    .core_reset_pulse(core_reset_pulse)
  );

  // photodiode only reaches the line outside transactions
  assign read_data_line_o = pass_mode ? photodiode_rx : rdl_out_reg;
  assign read_data_line_oe = pass_mode ? ctrl0_reg[RXOE_BIT] : rdl_oe_reg;
  // idle write line drives the LED
  assign led_drive = write_data_line & led_en_reg & ctrl0_reg[TXEN_BIT];

  property p_led_off;
    @(posedge sclk) disable iff (!srst_n)
    (state_reg == ST_IDLE) |=> (state_reg == ST_CMD) && !led_drive;
  endproperty
  a_led_off: assert property (p_led_off) else $error("LED not off");

  property p_resp_start;
    @(posedge sclk) disable iff (!srst_n)
    (end_rd ##1 write_data_line [*4]) |=>
      (state_reg == ST_RESP) && (rdl_out_reg == START_RD) && (rdl_oe_reg == sel_rd_reg);
  endproperty
  a_resp_start: assert property (p_resp_start) else $error("Late start bit");

  property p_ack;
    @(posedge sclk) disable iff (!srst_n)
    ack_go |=> (read_data_line_oe && (read_data_line_o == ACK_RD)) ##1
      (pass_mode && !rdl_oe_reg);
  endproperty
  a_ack: assert property (p_ack) else $error("Bad acknowledge");

  property p_no_ack;
    @(posedge sclk) disable iff (!srst_n)
    (end_wr && !ctrl0_reg[ACKNOWLEDGE_ENABLE_BIT_BIT]) |=> (state_reg == ST_IDLE) && !rdl_oe_reg;
  endproperty
  a_no_ack: assert property (p_no_ack) else $error("Unwanted acknowledge");

  property p_isolate;
    @(posedge sclk) disable iff (!srst_n)
    (state_reg inside {ST_GAP, ST_RESP, ST_DONE}) |->
      (read_data_line_oe == rdl_oe_reg) && (read_data_line_o == rdl_out_reg);
  endproperty
  a_isolate: assert property (p_isolate) else $error("Photodiode leaked");

  property p_forced_drive;
    @(posedge sclk) disable iff (!srst_n)
    (state_reg == ST_RESP && sel_rd_reg && !ctrl0_reg[RXOE_BIT]) |-> read_data_line_oe;
  endproperty
  a_forced_drive: assert property (p_forced_drive) else $error("Read not driven");

  property p_unaddressed;
    @(posedge sclk) disable iff (!srst_n)
    (!pass_mode && !sel_rd_reg && !sel_wr_reg) |-> !read_data_line_oe;
  endproperty
  a_unaddressed: assert property (p_unaddressed) else $error("Foreign drive");

  property p_read_end;
    @(posedge sclk) disable iff (!srst_n)
    (state_reg == ST_DONE && line_low) |=> (state_reg == ST_TAIL && !read_data_line_oe)
      ##1 (state_reg == ST_IDLE && led_en_reg);
  endproperty
  a_read_end: assert property (p_read_end) else $error("Read end missed");

  property p_led_back;
    @(posedge sclk) disable iff (!srst_n)
    end_wr |=> led_en_reg;
  endproperty
  a_led_back: assert property (p_led_back) else $error("LED not restored");

  property p_pass;
    @(posedge sclk) disable iff (!srst_n)
    (state_reg == ST_IDLE && led_en_reg && ctrl0_reg[TXEN_BIT]) |->
      (led_drive == write_data_line);
  endproperty
  a_pass: assert property (p_pass) else $error("LED path broken");

  property p_init;
    @(posedge sclk) disable iff (!srst_n)
    (state_reg == ST_INIT && write_data_line) |=>
      (state_reg == ST_INIT) && (init_cnt_reg == 5'h00);
  endproperty
  a_init: assert property (p_init) else $error("Init not restarted");

  c_read: cover property (@(posedge sclk) disable iff (!srst_n)
    (state_reg == ST_DONE) ##1 (state_reg == ST_TAIL));
  c_ack: cover property (@(posedge sclk) disable iff (!srst_n) ack_go);
  c_write: cover property (@(posedge sclk) disable iff (!srst_n) reg_we);
  c_reset: cover property (@(posedge sclk) disable iff (!srst_n) reg_rst);
endmodule : transceiver_serial_control_slave

// ===== testbench/serial_master.sv
// Serial bus master model: link clock and write line
`timescale 1ns/1ps
module serial_master (
  output logic sclk,
  output logic wdl,
  input wire logic rd
);
  logic smp; // Read line seen at the last rising edge
  initial begin
    sclk = 1'b0;
    wdl = 1'b0;
  end
  // idle line level, clock stays still
  task automatic level(input logic b);
    wdl = b;
  endtask : level
  // change at the fall, sample at the rise
  task automatic tick(input logic b);
    wdl = b;
    #3 smp = rd;
    sclk = 1'b1;
    #3 sclk = 1'b0;
  endtask : tick
  task automatic send(input logic [7:0] v);
    tick(1'b1);
    for (int i = 0; i < 8; i++) tick(v[i]);
  endtask : send
  // low-line clocks; extra two cover the reset sync
  task automatic init();
    repeat (32) tick(1'b0);
  endtask : init
  // write; one edge more only for an acknowledge
  task automatic wr(input logic [2:0] a, input logic [3:0] x, input logic [7:0] d,
                    input logic ack, input logic one, output logic seen);
    send({x, 1'b0, a});
    if (!one) send(d);
    seen = 1'b1;
    if (ack) begin
      tick(1'b0);
      seen = smp;
    end else begin
      // Let time pass so the next call does not drive the line twice at once
      wdl = 1'b0;
      #1;
    end
  endtask : wr
  // read: line high, lowered two edges before the end
  task automatic rd_txn(input logic [2:0] a, input logic [3:0] x, output logic [8:0] got);
    send({x, 1'b1, a});
    if (x == 4'hf) send(8'h00);
    for (int k = 1; k <= 13; k++) begin
      tick(1'b1);
      if (k >= 5) got[k-5] = smp;
    end
    tick(1'b0);
    tick(1'b0);
  endtask : rd_txn
endmodule : serial_master

// ===== testbench/tb.sv
// Self-checking bench of the serial control slave
`timescale 1ns/1ps
module tb;
  import serial_ctrl_pkg::*;
  logic mclk, rst_n, sclk, wdl, pd, rd_o, rd_oe, led, act, rpulse, seen;
  logic [MODE_W-1:0] mode;
  logic [POWER_W-1:0] pwr;
  logic [8:0] got;
  int bad_count, num_checks, pulses, p0;
  wire rd_line = rd_oe ? rd_o : 1'b1; // Weak pull-up while released
  localparam logic [7:0] ID_CODE = 8'h5a; // Arbitrary identity value
  // single transceiver, the only one with receiver enabled
  transceiver_serial_control_slave #(.EXT_ID_CODE(ID_CODE)) DUT (.mclk(mclk), .rst_n(rst_n),
    .sclk(sclk),
    .write_data_line(wdl), .photodiode_rx(pd), .read_data_line_o(rd_o),
    .read_data_line_oe(rd_oe), .led_drive(led), .core_active(act), .core_ir_mode(mode),
    .core_tx_power(pwr), .core_reset_pulse(rpulse));
  serial_master M (.sclk(sclk), .wdl(wdl), .rd(rd_line));
  always #2.5 mclk = ~mclk;
  // Count one-cycle reset pulses in the core domain
  always @(posedge mclk) if (rpulse === 1'b1) pulses++;
  task automatic check(input string what, input logic [15:0] val, input logic [15:0] exp);
    num_checks++;
    if (val !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, val);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  // Bounded wait for the core copies, since they cross domains
  task automatic settle(input logic [12:0] exp);
    int n;
    n = 0;
    while ({act, mode, pwr} !== exp && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("core", 16'({act, mode, pwr}), 16'(exp));
    if ({act, mode, pwr} !== exp) conclude();
  endtask : settle
  task automatic t_regs();
    M.wr(ADDR_INDIVIDUAL, IDX_CTRL1, 8'ha5, 1'b0, 1'b0, seen);
    settle({1'b0, 8'ha5, 4'h7});
    M.rd_txn(ADDR_INDIVIDUAL, IDX_CTRL1, got);
    check("read1", 16'(got), 16'h014a);
    M.wr(ADDR_INDIVIDUAL, IDX_CTRL2, 8'h3c, 1'b0, 1'b0, seen);
    settle({1'b0, 8'ha5, 4'h3});
    M.rd_txn(ADDR_INDIVIDUAL, IDX_CTRL2, got);
    check("read2", 16'(got), 16'h0060);
    $display("regs done");
  endtask : t_regs
  task automatic t_refuse();
    M.rd_txn(3'h3, IDX_CTRL1, got);
    check("other", 16'(got), 16'h01ff);
    M.rd_txn(ADDR_BROADCAST, IDX_CTRL1, got);
    check("bcast rd", 16'(got), 16'h01ff);
    M.wr(ADDR_BROADCAST, IDX_CTRL1, 8'h3c, 1'b0, 1'b0, seen);
    M.wr(3'h5, IDX_CTRL1, 8'h11, 1'b0, 1'b0, seen);
    M.rd_txn(ADDR_INDIVIDUAL, IDX_CTRL1, got);
    check("bcast wr", 16'(got), 16'h0078);
    $display("refuse done");
  endtask : t_refuse
  task automatic t_pass();
    M.wr(ADDR_INDIVIDUAL, IDX_CTRL0, 8'h06, 1'b0, 1'b0, seen);
    M.level(1'b1);
    @(posedge mclk);
    check("led on", 16'(led), 16'h0001);
    M.tick(1'b1);
    check("led off", 16'(led), 16'h0000);
    for (int i = 0; i < 8; i++) M.tick(i == 1);
    M.send(8'h07);
    settle({1'b1, 8'h3c, 4'h3});
    M.level(1'b1);
    @(posedge mclk);
    check("led back", 16'(led), 16'h0001);
    M.level(1'b0);
    #1 pd = 1'b1;
    @(posedge mclk);
    check("rx pass", 16'(rd_line), 16'h0001);
    #1 pd = 1'b0;
    @(posedge mclk);
    check("rx low", 16'(rd_line), 16'h0000);
    $display("pass done");
  endtask : t_pass
  task automatic t_ack();
    M.wr(ADDR_INDIVIDUAL, IDX_CTRL0, 8'h0f, 1'b0, 1'b0, seen);
    M.wr(ADDR_INDIVIDUAL, IDX_CTRL1, 8'h22, 1'b1, 1'b0, seen);
    check("ack wr", 16'(seen), 16'(ACK_RD));
    p0 = pulses;
    M.wr(ADDR_INDIVIDUAL, IDX_RESET, 8'h00, 1'b1, 1'b1, seen);
    check("ack sp", 16'(seen), 16'(ACK_RD));
    settle({1'b0, 8'h00, 4'h7});
    // The pulse counter sees the pulse one core cycle after it is launched
    repeat (2) @(posedge mclk);
    check("pulse", 16'(pulses - p0), 16'h0001);
    $display("ack done");
  endtask : t_ack
  task automatic t_ext();
    M.rd_txn(ADDR_INDIVIDUAL, IDX_EXT, got);
    check("ext id", 16'(got), 16'({ID_CODE, 1'b0}));
    $display("ext done");
  endtask : t_ext
  // Mid-run reset, then an init that a high line restarts
  task automatic t_restart();
    M.wr(ADDR_INDIVIDUAL, IDX_CTRL1, 8'h5a, 1'b0, 1'b0, seen);
    @(posedge mclk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    settle({1'b0, MODE_RESET, POWER_RESET});
    repeat (4) M.tick(1'b0);
    M.tick(1'b1);
    repeat (30) M.tick(1'b0);
    M.rd_txn(ADDR_INDIVIDUAL, IDX_CTRL1, got);
    check("restart", 16'(got), 16'({MODE_RESET, 1'b0}));
    $display("restart done");
  endtask : t_restart
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    pd = 1'b0;
    bad_count = 0;
    num_checks = 0;
    pulses = 0;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    check("oe", 16'(rd_oe), 16'h0000);
    settle({1'b0, MODE_RESET, POWER_RESET});
    $display("reset done");
    #1.3 M.init();
    t_regs();
    t_refuse();
    t_pass();
    t_ack();
    t_ext();
    t_restart();
    conclude();
  end
endmodule : tb
